/* verilog/sdif_top.sv */
// The placing of the registers and register access over Avalon-MM are this design's own decisions.
`timescale 1ns/1ps
module sdif_top (
    input wire logic i_clk,                   // 100 MHz clock
    input wire logic i_reset_n,               // async reset, active low
    input wire logic i_ce,                    // clock enable
    input wire logic [4:0] i_avs_address,     // byte address
    input wire logic i_avs_read,              // read strobe
    input wire logic i_avs_write,             // write strobe
    input wire logic [31:0] i_avs_writedata,  // write data
    output logic [31:0] o_avs_readdata,       // read data
    output logic o_avs_waitrequest,           // stall
    input wire logic i_alarm_clear_input,     // alarm clear pin
    input wire logic i_motor_energize_input,  // energize pin
    input wire logic i_command_hold_input,    // command hold pin
    input wire logic i_gain_select_a,         // gain select A pin
    input wire logic i_gain_select_b,         // gain select B pin
    input wire logic [7:0] i_alarm_events,    // alarm causes
    input wire logic i_cmd_valid,             // motion command strobe
    input wire logic [15:0] i_cmd_velocity,   // command velocity
    input wire logic i_pos_pulse,             // position pulse
    output logic o_alarm,                     // any alarm latched
    output logic o_current_on,                // motor excited
    output logic [15:0] o_velocity,           // applied velocity
    output logic [1:0] o_gain_set,            // active gain set
    output logic o_irq                        // interrupt
);
    sdif_bus_if bus ();
    logic [7:0] pol;
    logic pos_mode;
    logic [3:0] irq_mask;
    logic [7:0] alarm_class;
    logic [4:0] act;
    logic bus_done;

    // =========================================================
    // state
    // =========================================================
    typedef struct packed {
        logic [7:0] alarms;
        logic clear_prev;
        sdif_pkg::sdif_motor_t mode;
        logic [15:0] vel;
        logic [1:0] gain;
        logic [31:0] count;
        logic [3:0] irq;
        logic ack;
    } sdif_state_t;
    sdif_state_t s_r, s_nxt;

    // =========================================================
    // input polarity
    // =========================================================
    genvar g;
    generate
        for (g = 0; g < sdif_pkg::sdif_n_inputs; g++) begin : g_pol
            logic raw;
            if (g == sdif_pkg::sdif_pol_clear) begin : g_c
                assign raw = i_alarm_clear_input;
            end else if (g == sdif_pkg::sdif_pol_energize) begin : g_e
                assign raw = i_motor_energize_input;
            end else if (g == sdif_pkg::sdif_pol_hold) begin : g_h
                assign raw = i_command_hold_input;
            end else if (g == sdif_pkg::sdif_pol_gain_a) begin : g_a
                assign raw = i_gain_select_a;
            end else begin : g_b
                assign raw = i_gain_select_b;
            end
            assign act[g] = raw ^ pol[g];
        end
    endgenerate

    // =========================================================
    // registers
    // =========================================================
    assign bus.address = i_avs_address;
    assign bus.read = i_avs_read & ~s_r.ack;
    assign bus.write = i_avs_write & ~s_r.ack;
    assign bus.writedata = i_avs_writedata;
    assign bus_done = (i_avs_read | i_avs_write) & s_r.ack;

    sdif_regs u_regs (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_ce(i_ce),
        .bus(bus),
        .i_status({20'h0, s_r.gain, s_r.mode == sdif_pkg::sdif_st_hold, o_current_on, s_r.alarms}),
        .i_irq_stat({28'h0, s_r.irq}),
        .i_count(s_r.count),
        .o_polarity(pol),
        .o_pos_mode(pos_mode),
        .o_irq_mask(irq_mask),
        .o_alarm_class(alarm_class)
    );

    // =========================================================
    // behaviour
    // =========================================================
    always_comb begin
        logic [sdif_pkg::sdif_n_irq-1:0] ev;
        ev = '0;
        s_nxt = s_r;
        s_nxt.ack = (i_avs_read | i_avs_write) & ~s_r.ack;
        s_nxt.clear_prev = act[sdif_pkg::sdif_pol_clear];
        if (act[sdif_pkg::sdif_pol_clear] && !s_r.clear_prev) begin
            s_nxt.alarms = s_r.alarms & alarm_class;
            ev[sdif_pkg::sdif_irq_cleared] = 1'b1;
        end
        s_nxt.alarms = s_nxt.alarms | i_alarm_events;
        if (|(i_alarm_events & ~s_r.alarms)) begin
            ev[sdif_pkg::sdif_irq_alarm] = 1'b1;
        end
        case (s_r.mode)
            sdif_pkg::sdif_st_off: begin
                s_nxt.vel = 16'h0;
                if (act[sdif_pkg::sdif_pol_energize]) begin
                    s_nxt.mode = sdif_pkg::sdif_st_run;
                    ev[sdif_pkg::sdif_irq_energize] = 1'b1;
                end
            end
            sdif_pkg::sdif_st_run: begin
                if (i_cmd_valid) begin
                    s_nxt.vel = i_cmd_velocity;
                end
                if (act[sdif_pkg::sdif_pol_hold]) begin
                    s_nxt.mode = sdif_pkg::sdif_st_hold;
                    s_nxt.vel = 16'h0;
                end
            end
            sdif_pkg::sdif_st_hold: begin
                s_nxt.vel = 16'h0;
                if (!act[sdif_pkg::sdif_pol_hold]) begin
                    s_nxt.mode = sdif_pkg::sdif_st_run;
                end
            end
            default: s_nxt.mode = sdif_pkg::sdif_st_off;
        endcase
        if (!act[sdif_pkg::sdif_pol_energize] && s_r.mode != sdif_pkg::sdif_st_off) begin
            s_nxt.mode = sdif_pkg::sdif_st_off;
            s_nxt.vel = 16'h0;
            ev[sdif_pkg::sdif_irq_energize] = 1'b1;
        end
        if (pos_mode && i_pos_pulse && !act[sdif_pkg::sdif_pol_hold]
                && s_r.mode == sdif_pkg::sdif_st_run) begin
            s_nxt.count = s_r.count + 32'h1;
        end
        s_nxt.gain = {act[sdif_pkg::sdif_pol_gain_b], act[sdif_pkg::sdif_pol_gain_a]};
        if (s_nxt.gain != s_r.gain) begin
            ev[sdif_pkg::sdif_irq_gain] = 1'b1;
        end
        if (bus.write && bus.address == {1'b0, sdif_pkg::sdif_adr_irq_stat}) begin
            s_nxt.irq = s_r.irq & ~i_avs_writedata[3:0];
        end
        s_nxt.irq = s_nxt.irq | ev;
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            s_r <= '{alarms: 8'h0, clear_prev: 1'b0, mode: sdif_pkg::sdif_st_off, vel: 16'h0,
                     gain: 2'h0, count: 32'h0, irq: 4'h0, ack: 1'b0};
        end else if (i_ce) begin
            s_r <= s_nxt;
        end
    end

    assign o_avs_readdata = bus.readdata;
    assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~bus_done;
    assign o_alarm = |s_r.alarms;
    assign o_current_on = s_r.mode != sdif_pkg::sdif_st_off;
    assign o_velocity = s_r.vel;
    assign o_gain_set = s_r.gain;
    assign o_irq = |(s_r.irq & irq_mask);
endmodule

/* verilog/sdif_pkg.sv */
// Contract
// - alarm clear input clears latched alarms and drops the alarm output.
// - alarms needing a power cycle stay active through alarm clear.
// - each input's active polarity follows its allocation option bit.
// - motor energize asserted puts the motor in current-applied state.
// - command hold during operation ignores commands, stops, keeps motor excited.
// - in position mode, pulses arriving under command hold are not counted.
// - four gain sets, chosen by the two gain-select inputs.
// - none valid set1, A only set2, B only set3, both set4.
package sdif_pkg;
    // =========================================================
    // register map (word byte addresses)
    // =========================================================
    localparam logic [3:0] sdif_adr_ctrl = 4'h0;
    localparam logic [3:0] sdif_adr_polarity = 4'h4;
    localparam logic [3:0] sdif_adr_status = 4'h8;
    localparam logic [3:0] sdif_adr_irq_stat = 4'hc;
    // addresses 0x10..0x18
    localparam logic [4:0] sdif_adr_irq_mask = 5'h10;
    localparam logic [4:0] sdif_adr_alarm_set = 5'h14;
    localparam logic [4:0] sdif_adr_pos_count = 5'h18;
    // =========================================================
    // field positions
    // =========================================================
    localparam int sdif_ctrl_pos_mode = 0;
    localparam int sdif_pol_clear = 0;
    localparam int sdif_pol_energize = 1;
    localparam int sdif_pol_hold = 2;
    localparam int sdif_pol_gain_a = 3;
    localparam int sdif_pol_gain_b = 4;
    localparam int sdif_n_inputs = 5;
    localparam int sdif_n_alarms = 8;
    localparam int sdif_irq_alarm = 0;
    localparam int sdif_irq_cleared = 1;
    localparam int sdif_irq_energize = 2;
    localparam int sdif_irq_gain = 3;
    localparam int sdif_n_irq = 4;
    // =========================================================
    // reset values
    // =========================================================
    localparam logic [7:0] sdif_rst_polarity = 8'h00;
    localparam logic [7:0] sdif_rst_power_cycle_class = 8'hf0;
    typedef enum logic [1:0] {sdif_gain1, sdif_gain2, sdif_gain3, sdif_gain4} sdif_gain_t;
    typedef enum {sdif_st_off, sdif_st_run, sdif_st_hold} sdif_motor_t;
endpackage

/* verilog/sdif_bus_if.sv */
`timescale 1ns/1ps
interface sdif_bus_if;
    logic [4:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [31:0] readdata;
    modport slave (input address, read, write, writedata, output readdata);
    modport master (output address, read, write, writedata, input readdata);
endinterface

/* verilog/sdif_regs.sv */
`timescale 1ns/1ps
module sdif_regs (
    input wire logic i_clk,              // clock
    input wire logic i_reset_n,          // async reset
    input wire logic i_ce,               // clock enable
    sdif_bus_if.slave bus,               // register access
    input wire logic [31:0] i_status,    // live status word
    input wire logic [31:0] i_irq_stat,  // sticky events
    input wire logic [31:0] i_count,     // pulse count
    output logic [7:0] o_polarity,       // polarity options
    output logic o_pos_mode,             // position mode
    output logic [3:0] o_irq_mask,       // interrupt mask
    output logic [7:0] o_alarm_class     // power-cycle class
);
    typedef struct packed {
        logic [7:0] pol;
        logic pos;
        logic [3:0] mask;
        logic [7:0] cls;
        logic [31:0] rd;
    } sdif_regs_t;
    sdif_regs_t q_r, q_nxt;
    always_comb begin
        q_nxt = q_r;
        if (bus.write) begin
            case (bus.address)
                {1'b0, sdif_pkg::sdif_adr_ctrl}: q_nxt.pos = bus.writedata[sdif_pkg::sdif_ctrl_pos_mode];
                {1'b0, sdif_pkg::sdif_adr_polarity}: q_nxt.pol = bus.writedata[7:0];
                sdif_pkg::sdif_adr_irq_mask: q_nxt.mask = bus.writedata[3:0];
                sdif_pkg::sdif_adr_alarm_set: q_nxt.cls = bus.writedata[7:0];
                default: q_nxt.pos = q_r.pos;
            endcase
        end
        case (bus.address)
            {1'b0, sdif_pkg::sdif_adr_ctrl}: q_nxt.rd = {31'h0, q_r.pos};
            {1'b0, sdif_pkg::sdif_adr_polarity}: q_nxt.rd = {24'h0, q_r.pol};
            {1'b0, sdif_pkg::sdif_adr_status}: q_nxt.rd = i_status;
            {1'b0, sdif_pkg::sdif_adr_irq_stat}: q_nxt.rd = i_irq_stat;
            sdif_pkg::sdif_adr_irq_mask: q_nxt.rd = {28'h0, q_r.mask};
            sdif_pkg::sdif_adr_alarm_set: q_nxt.rd = {24'h0, q_r.cls};
            sdif_pkg::sdif_adr_pos_count: q_nxt.rd = i_count;
            default: q_nxt.rd = 32'h0;
        endcase
    end
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            q_r <= '{pol: sdif_pkg::sdif_rst_polarity, pos: 1'b0, mask: 4'h0,
                     cls: sdif_pkg::sdif_rst_power_cycle_class, rd: 32'h0};
        end else if (i_ce) begin
            q_r <= q_nxt;
        end
    end
    assign bus.readdata = q_r.rd;
    assign o_polarity = q_r.pol;
    assign o_pos_mode = q_r.pos;
    assign o_irq_mask = q_r.mask;
    assign o_alarm_class = q_r.cls;
endmodule

/* test/sdif_host_model.sv */
`timescale 1ns/1ps
module sdif_host_model (
    input wire logic [4:0] i_pol,  // polarity options
    input wire logic [4:0] i_req,  // logical requests
    output logic [4:0] o_pins      // pin levels
);
    // =========================================
    // pin level = request xor polarity option
    // =========================================
    assign o_pins = i_req ^ i_pol;
endmodule

/* test/sdif_assertions.sv */
`timescale 1ns/1ps
module sdif_assertions (
    input wire logic i_clk, input wire logic i_reset_n, input wire logic i_ce,
    input wire logic [4:0] i_avs_address, input wire logic i_avs_read, input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata, input wire logic o_avs_waitrequest,
    input wire logic i_alarm_clear_input, input wire logic i_motor_energize_input,
    input wire logic i_command_hold_input, input wire logic i_gain_select_a, input wire logic i_gain_select_b,
    input wire logic [7:0] i_alarm_events, input wire logic o_alarm, input wire logic o_current_on,
    input wire logic [15:0] o_velocity, input wire logic [1:0] o_gain_set
);
    logic [4:0] pol_r;
    logic [7:0] cls_r;
    logic clr_d_r;
    logic [7:0] al_r;
    logic take;
    logic [4:0] act;
    assign take = i_avs_write && o_avs_waitrequest && i_ce;
    assign act = {i_gain_select_b, i_gain_select_a, i_command_hold_input, i_motor_energize_input,
        i_alarm_clear_input} ^ pol_r;
    // =========================================
    // shadow of polarity and alarm class
    // =========================================
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            pol_r <= sdif_pkg::sdif_rst_polarity[4:0];
            cls_r <= sdif_pkg::sdif_rst_power_cycle_class;
            clr_d_r <= 1'b0;
            al_r <= 8'h00;
        end else begin
            if (act[0] && !clr_d_r) al_r <= (al_r & cls_r) | i_alarm_events;
            else al_r <= al_r | i_alarm_events;
            if (take && i_avs_address == {1'b0, sdif_pkg::sdif_adr_polarity}) pol_r <= i_avs_writedata[4:0];
            if (take && i_avs_address == sdif_pkg::sdif_adr_alarm_set) cls_r <= i_avs_writedata[7:0];
            clr_d_r <= act[0];
        end
    end
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    a_energize_on: assert property (act[1] |=> o_current_on)
        else $error("current not applied");
    a_energize_off: assert property (!act[1] |=> !o_current_on && o_velocity == 16'h0000)
        else $error("current not removed");
    a_gain_map: assert property (o_gain_set == $past(act[4:3]))
        else $error("wrong gain set");
    a_hold_stop: assert property (act[1] && act[2] |=> o_current_on && o_velocity == 16'h0000)
        else $error("hold did not stop excited");
    a_alarm_latch: assert property (i_alarm_events != 8'h00 |=> o_alarm)
        else $error("alarm not latched");
    a_alarm_clear: assert property (act[0] && !clr_d_r && i_alarm_events == 8'h00 && cls_r == 8'h00 |=> !o_alarm)
        else $error("alarm not cleared");
    a_alarm_keep: assert property ((al_r & cls_r) != 8'h00 |-> o_alarm)
        else $error("power cycle alarm lost");
    a_wait_one: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
        else $error("bus answer late");
    c_hold: cover property (act[1] && act[2]);
    c_clear: cover property (act[0] && !clr_d_r && o_alarm);
    c_gain4: cover property (act[4:3] == 2'b11);
endmodule
bind sdif_top sdif_assertions u_chk (.*);

/* test/testbench.sv */
`timescale 1ns/1ps
module testbench;
    logic i_clk, rstn, rd, wr, cmdv, pulse, wreq, alarm, cur, irq;
    logic [4:0] addr, req, pol, pins;
    logic [31:0] wdata, rdata, q;
    logic [7:0] ev;
    logic [15:0] vel;
    logic [1:0] gain;
    int miscompares = 0;
    int checked = 0;
    sdif_host_model host (.i_pol(pol), .i_req(req), .o_pins(pins));
    sdif_top DUT (.i_clk(i_clk), .i_reset_n(rstn), .i_ce(1'b1), .i_avs_address(addr), .i_avs_read(rd),
        .i_avs_write(wr), .i_avs_writedata(wdata), .o_avs_readdata(rdata), .o_avs_waitrequest(wreq),
        .i_alarm_clear_input(pins[0]), .i_motor_energize_input(pins[1]), .i_command_hold_input(pins[2]),
        .i_gain_select_a(pins[3]), .i_gain_select_b(pins[4]), .i_alarm_events(ev), .i_cmd_valid(cmdv),
        .i_cmd_velocity(16'h1234), .i_pos_pulse(pulse), .o_alarm(alarm), .o_current_on(cur),
        .o_velocity(vel), .o_gain_set(gain), .o_irq(irq));
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    task automatic summarize;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    // =========================================
    // bus cycle, entered just after an edge
    // =========================================
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        int n;
        n = 0;
        addr <= a;
        wdata <= d;
        wr <= w;
        rd <= !w;
        @(posedge i_clk);
        while (wreq !== 1'b0) begin
            n++;
            if (n > 50) begin
                miscompares++;
                summarize();
            end
            @(posedge i_clk);
        end
        q = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
        // one idle edge so the next request is a fresh rise
        @(posedge i_clk);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
    endtask
    task automatic pulses;
        repeat (3) begin
            pulse <= 1'b1;
            tick(1);
            pulse <= 1'b0;
            tick(1);
        end
    endtask
    task automatic t_regs;
        bus(0, 5'h04, 0); cmp("polarity", 32'h0, q);
        bus(0, 5'h14, 0); cmp("class", 32'hf0, q);
        bus(0, 5'h1c, 0); cmp("unmapped", 32'h0, q);
    endtask
    task automatic t_gain(input logic [4:0] p);
        bus(1, 5'h04, {27'h0, p});
        pol <= p;
        for (int g = 0; g < 4; g++) begin
            req[4:3] <= g[1:0];
            tick(2);
            cmp("gain", g, {30'h0, gain});
        end
        req[4:3] <= 2'b00;
        tick(2);
    endtask
    task automatic t_irq;
        cmp("irq masked", 0, irq);
        bus(1, 5'h10, 32'h8); tick(1); cmp("irq", 1, irq);
        bus(1, 5'h0c, 32'h8); tick(1); cmp("irq w1c", 0, irq);
    endtask
    task automatic t_power;
        logic [31:0] c0;
        req[1] <= 1'b1;
        bus(1, 5'h00, 32'h1);
        tick(2); cmp("on", 1, cur);
        cmdv <= 1'b1; tick(1); cmdv <= 1'b0;
        tick(1); cmp("run vel", 32'h1234, {16'h0, vel});
        req[2] <= 1'b1;
        tick(2); cmp("held vel", 0, vel);
        cmdv <= 1'b1; tick(1); cmdv <= 1'b0;
        tick(2); cmp("held cmd", 0, vel);
        cmp("held on", 1, cur);
        bus(0, 5'h18, 0); c0 = q;
        pulses(); bus(0, 5'h18, 0); cmp("held count", c0, q);
        req[2] <= 1'b0;
        tick(2); pulses(); bus(0, 5'h18, 0); cmp("count", c0 + 3, q);
        req[1] <= 1'b0;
        tick(2); cmp("off", 0, cur);
        cmp("off vel", 0, vel);
    endtask
    task automatic t_alarm;
        ev <= 8'h11; tick(1); ev <= 8'h00;
        tick(2); cmp("alarm", 1, alarm);
        req[0] <= 1'b1; tick(2); req[0] <= 1'b0;
        bus(0, 5'h08, 0); cmp("kept", 32'h10, {24'h0, q[7:0]});
        cmp("alarm kept", 1, alarm);
        bus(1, 5'h14, 32'h0);
        req[0] <= 1'b1; tick(2); req[0] <= 1'b0;
        cmp("cleared", 0, alarm);
    endtask
    initial begin
        rstn = 1'b0; rd = 1'b0; wr = 1'b0; cmdv = 1'b0; pulse = 1'b0;
        addr = 5'h00; req = 5'h00; pol = 5'h00; wdata = 32'h0; ev = 8'h00;
        tick(8);
        rstn <= 1'b1;
        tick(1);
        t_regs();
        t_gain(5'h00);
        t_gain(5'h1f);
        t_gain(5'h00);
        t_irq();
        t_power();
        t_alarm();
        summarize();
    end
endmodule
